// >>> include/pin_mode_pkg.sv
// shared types, constants and helpers for the converter pin-mode decode block
package pin_mode_pkg;

  // resolved level of a three-level strap pin
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_t;

  // calibration sequencer states
  typedef enum logic [1:0] {ST_STRAP, ST_POWERUP, ST_IDLE, ST_CALIBRATE} cal_state_t;

  // width of every cycle counter in the block
  localparam int unsigned CNT_W = 13;

  // full-scale code width and the two pin-selected codes
  localparam int unsigned FS_W = 9;
  localparam logic [8:0] FS_CODE_REDUCED = 9'h0C0;
  localparam logic [8:0] FS_CODE_HIGHER = 9'h1FF;
  localparam logic [8:0] FS_ADJUST_RESET = 9'h100;

  // timing figures, all counted in clock_in cycles
  localparam logic [12:0] CAL_LOW_MIN_CYC = 13'h0050;
  localparam logic [12:0] CAL_HIGH_MIN_CYC = 13'h0050;
  localparam logic [12:0] POWERUP_SHORT_CYC = 13'h0100;
  localparam logic [12:0] POWERUP_LONG_CYC = 13'h1000;
  localparam logic [12:0] CAL_RUN_CYC = 13'h0578;
  localparam logic [12:0] CNT_ZERO = 13'h0000;
  localparam logic [12:0] CNT_ONE = 13'h0001;

  // two threshold comparators into one level; both set is a pad fault, read as mid
  function automatic level_t resolve_level(input logic above_hi, input logic below_lo);
    level_t lvl;
    lvl = LVL_MID;
    if (above_hi && !below_lo) begin
      lvl = LVL_HIGH;
    end else if (below_lo && !above_hi) begin
      lvl = LVL_LOW;
    end
    return lvl;
  endfunction : resolve_level

  // saturating increment for run-length counters
  function automatic logic [12:0] sat_inc(input logic [12:0] v);
    return (v == 13'h1FFF) ? v : v + 13'h0001;
  endfunction : sat_inc

endpackage : pin_mode_pkg

// >>> core/level_resolver.sv
// three-level strap resolver for the range-select pin
`timescale 1ns/1ns
`default_nettype none
module level_resolver (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // pad comparator outputs
  input wire logic above_hi_in,
  input wire logic below_lo_in,
  // resolved level
  output pin_mode_pkg::level_t level_out
);

  // combinational resolution, used once here
  pin_mode_pkg::level_t level_nxt;
  assign level_nxt = pin_mode_pkg::resolve_level(above_hi_in, below_lo_in);

  // registered so the decode never sees a comparator glitch mid-cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      level_out <= pin_mode_pkg::LVL_MID;
    end else begin
      level_out <= level_nxt;
    end
  end

endmodule : level_resolver
`default_nettype wire

// >>> core/cycle_counter.sv
// loadable down counter with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module cycle_counter (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // load request and count
  input wire logic load_in,
  input wire logic [12:0] load_value_in,
  // status
  output logic busy_out,
  output logic done_out
);

  logic [12:0] count_r; // cycles still to run
  logic [12:0] count_nxt;

  // load wins over counting; idle at zero
  assign count_nxt = load_in ? load_value_in :
                     (count_r != pin_mode_pkg::CNT_ZERO) ? count_r - pin_mode_pkg::CNT_ONE :
                     count_r;

  assign busy_out = (count_r != pin_mode_pkg::CNT_ZERO);

  // count register and done pulse the cycle after the last counted cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      count_r <= pin_mode_pkg::CNT_ZERO;
      done_out <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_out <= !load_in && (count_r == pin_mode_pkg::CNT_ONE);
    end
  end

endmodule : cycle_counter
`default_nettype wire

// >>> core/adc_pin_mode_decode.sv
// strap decode, calibration sequencing and sample edge for a dual converter
//
// Notes on behaviour
// RQ1 - range pin usable only when both mode pins high
// RQ2 - range pin low selects reduced full scale
// RQ3 - range pin high selects higher full scale
// RQ4 - range pin mid-level enables extended control
// RQ5 - primary extended enable overrides alternate enable
// RQ6 - clock-reset mode low: range pin is negative leg
// RQ7 - differential reset mode defaults to higher range
// RQ8 - valid range level, primary high: delay select
// RQ9 - floating range, primary low: serial chip select
// RQ10 - chip-select configuration forces calibration delay zero
// RQ11 - sample on falling edge of clock positive leg
// RQ12 - extended mode takes range from adjust register
// RQ13 - initiate low then high starts calibration
// RQ14 - running output high throughout calibration
// RQ15 - range pin resolves to exactly three levels
`timescale 1ns/1ns
`default_nettype none
module adc_pin_mode_decode (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // range-select pin, seen through two pad comparators
  input wire logic full_scale_select_above_in,
  input wire logic full_scale_select_below_in,
  // mode straps; a floating pad reads high through its pull-up
  input wire logic extended_enable_n_in,
  input wire logic output_clock_reset_mode_in,
  // delay-select / chip-select pin
  input wire logic calibration_delay_select_in,
  // calibration initiate pin
  input wire logic calibration_initiate_in,
  // positive leg of the input clock, sampled as a level
  input wire logic input_clock_p_in,
  // full-scale adjust value from the control register bank
  input wire logic [8:0] full_scale_adjust_in,
  // decoded modes
  output logic extended_mode_out,
  output logic alternate_extended_enable_out,
  output logic output_clock_reset_diff_out,
  output logic output_clock_reset_neg_out,
  // delay-select pin functions
  output logic serial_chip_select_enable_out,
  output logic serial_chip_select_out,
  output logic calibration_delay_long_out,
  // full-scale range
  output logic [8:0] full_scale_code_out,
  output logic full_scale_from_register_out,
  // calibration and sampling
  output logic calibration_running_out,
  output logic sample_strobe_out
);

  // ---------------------------------------------------------------
  // range pin level
  // ---------------------------------------------------------------

  pin_mode_pkg::level_t fs_level; // resolved range pin level

  // three distinct states from two comparators [RQ15]
  level_resolver u_level (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .above_hi_in(full_scale_select_above_in),
    .below_lo_in(full_scale_select_below_in),
    .level_out(fs_level)
  );

  wire fs_low = (fs_level == pin_mode_pkg::LVL_LOW);
  wire fs_high = (fs_level == pin_mode_pkg::LVL_HIGH);
  wire fs_mid = (fs_level == pin_mode_pkg::LVL_MID);

  // ---------------------------------------------------------------
  // mode decode, all continuous
  // ---------------------------------------------------------------

  // low on the clock-reset mode pin turns the range pin into a clock leg [RQ6]
  wire diff_mode = !output_clock_reset_mode_in;

  // range pin owns its function only with both straps high [RQ1]
  wire pin_range_use = extended_enable_n_in && output_clock_reset_mode_in;

  // alternate enable: mid-level or floating range pin [RQ4]
  wire alt_enable = pin_range_use && fs_mid;

  // primary enable wins whatever the range pin says [RQ5]
  wire ext_mode = !extended_enable_n_in || alt_enable;

  // delay pin is chip select exactly when extended control is on [RQ9]
  wire scs_function = ext_mode;

  // long delay only in the calibration-delay configuration [RQ8] [RQ10]
  wire delay_long = !scs_function && calibration_delay_select_in;

  // full-scale choice, one source per combination [RQ2] [RQ3] [RQ7] [RQ12]
  wire [8:0] fs_code = ext_mode ? full_scale_adjust_in :
                       diff_mode ? pin_mode_pkg::FS_CODE_HIGHER :
                       fs_low ? pin_mode_pkg::FS_CODE_REDUCED :
                       pin_mode_pkg::FS_CODE_HIGHER;

  // negative clock-reset leg: the pin's own low/high state, only in diff mode
  wire neg_leg = diff_mode && !fs_low;

  // ---------------------------------------------------------------
  // registered mode outputs
  // ---------------------------------------------------------------

  // every decoded output leaves through a flop
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      extended_mode_out <= 1'b0;
      alternate_extended_enable_out <= 1'b0;
      output_clock_reset_diff_out <= 1'b0;
      output_clock_reset_neg_out <= 1'b0;
      serial_chip_select_enable_out <= 1'b0;
      serial_chip_select_out <= 1'b0;
      calibration_delay_long_out <= 1'b0;
      full_scale_code_out <= pin_mode_pkg::FS_CODE_HIGHER;
      full_scale_from_register_out <= 1'b0;
    end else begin
      extended_mode_out <= ext_mode;
      alternate_extended_enable_out <= alt_enable;
      output_clock_reset_diff_out <= diff_mode;
      output_clock_reset_neg_out <= neg_leg; // [RQ6]
      serial_chip_select_enable_out <= scs_function;
      // chip select passes only in its own function
      serial_chip_select_out <= scs_function && calibration_delay_select_in; // [RQ9]
      calibration_delay_long_out <= delay_long;
      full_scale_code_out <= fs_code;
      full_scale_from_register_out <= ext_mode; // [RQ12]
    end
  end

  // ---------------------------------------------------------------
  // sample edge
  // ---------------------------------------------------------------

  logic clk_p_prev_r; // previous level of the clock positive leg

  // falling edge of the positive leg marks the sample instant [RQ11]
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      clk_p_prev_r <= 1'b0;
      sample_strobe_out <= 1'b0;
    end else begin
      clk_p_prev_r <= input_clock_p_in;
      sample_strobe_out <= clk_p_prev_r && !input_clock_p_in; // [RQ11]
    end
  end

  // ---------------------------------------------------------------
  // calibration initiate qualifier
  // ---------------------------------------------------------------

  logic [12:0] low_run_r; // consecutive low cycles on the initiate pin
  logic [12:0] high_run_r; // consecutive high cycles after a long enough low
  logic armed_r; // a qualifying low period has been seen
  pin_mode_pkg::cal_state_t state_r;
  pin_mode_pkg::cal_state_t state_nxt;

  wire low_done = (low_run_r >= pin_mode_pkg::CAL_LOW_MIN_CYC);
  wire high_done = armed_r && (high_run_r >= pin_mode_pkg::CAL_HIGH_MIN_CYC);
  // a request waits for idle rather than being dropped mid-sequence
  wire cal_trigger = high_done && (state_r == pin_mode_pkg::ST_IDLE);

  // run-length counters; a fresh low period re-arms, the set wins over the clear
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      low_run_r <= pin_mode_pkg::CNT_ZERO;
      high_run_r <= pin_mode_pkg::CNT_ZERO;
      armed_r <= 1'b0;
    end else begin
      low_run_r <= calibration_initiate_in ? pin_mode_pkg::CNT_ZERO :
                   pin_mode_pkg::sat_inc(low_run_r);
      high_run_r <= (calibration_initiate_in && armed_r) ?
                    pin_mode_pkg::sat_inc(high_run_r) : pin_mode_pkg::CNT_ZERO;
      if (low_done) begin
        armed_r <= 1'b1; // [RQ13]
      end else if (cal_trigger) begin
        armed_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // calibration sequencer
  // ---------------------------------------------------------------

  logic timer_load;
  logic [12:0] timer_value;
  logic timer_busy;
  logic timer_done;
  logic strap_wait_r; // range level still shows its reset value
  logic [12:0] run_len_r; // cycles the running flag has stood high

  // one timer serves the power-up wait and the calibration run
  cycle_counter u_timer (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .load_in(timer_load),
    .load_value_in(timer_value),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  // next state and timer load
  always_comb begin
    state_nxt = state_r;
    timer_load = 1'b0;
    timer_value = pin_mode_pkg::CAL_RUN_CYC;
    unique case (state_r)
      // straps caught only once the resolver left its reset level, else mid fakes ext mode
      pin_mode_pkg::ST_STRAP: begin
        if (!strap_wait_r) begin
          timer_load = 1'b1;
          timer_value = delay_long ? pin_mode_pkg::POWERUP_LONG_CYC :
                        pin_mode_pkg::POWERUP_SHORT_CYC; // [RQ8] [RQ10]
          state_nxt = pin_mode_pkg::ST_POWERUP;
        end
      end
      // power-up wait, then the first calibration
      pin_mode_pkg::ST_POWERUP: begin
        if (timer_done) begin
          timer_load = 1'b1;
          state_nxt = pin_mode_pkg::ST_CALIBRATE;
        end
      end
      // waiting for an initiate request
      pin_mode_pkg::ST_IDLE: begin
        if (cal_trigger) begin
          timer_load = 1'b1; // [RQ13]
          state_nxt = pin_mode_pkg::ST_CALIBRATE;
        end
      end
      // calibration in progress
      pin_mode_pkg::ST_CALIBRATE: begin
        if (timer_done) begin
          state_nxt = pin_mode_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // state register and running flag
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r <= pin_mode_pkg::ST_STRAP;
      calibration_running_out <= 1'b0;
      strap_wait_r <= 1'b1;
      run_len_r <= pin_mode_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      calibration_running_out <= (state_nxt == pin_mode_pkg::ST_CALIBRATE); // [RQ14]
      strap_wait_r <= 1'b0;
      // helper for the run-length check; too long for a delay range
      run_len_r <= calibration_running_out ? pin_mode_pkg::sat_inc(run_len_r) :
                   pin_mode_pkg::CNT_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // reduced range follows a low range pin in pin mode
  range_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ2]
    (pin_range_use && fs_low) |=> (full_scale_code_out == pin_mode_pkg::FS_CODE_REDUCED))
    else $error("low range pin did not give reduced range");

  // higher range follows a high range pin in pin mode
  range_high_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ3]
    (pin_range_use && fs_high) |=> (full_scale_code_out == pin_mode_pkg::FS_CODE_HIGHER))
    else $error("high range pin did not give higher range");

  // mid-level pin with both straps high turns on extended control
  alt_enable_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ4]
    (extended_enable_n_in && output_clock_reset_mode_in && fs_mid)
    |=> (extended_mode_out && alternate_extended_enable_out))
    else $error("mid-level range pin did not enable extended control");

  // primary enable forces extended mode whatever the range pin
  primary_wins_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ5]
    !extended_enable_n_in |=> (extended_mode_out && serial_chip_select_enable_out))
    else $error("primary enable was overridden");

  // differential reset mode: no alternate enable, higher range unless extended
  diff_default_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ7]
    (!output_clock_reset_mode_in && extended_enable_n_in)
    |=> (!alternate_extended_enable_out && output_clock_reset_diff_out
         && full_scale_code_out == pin_mode_pkg::FS_CODE_HIGHER))
    else $error("differential reset mode did not default to higher range");

  // straps qualify the range pin only when both are high
  range_gate_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ1]
    (!extended_enable_n_in || !output_clock_reset_mode_in) |=> !alternate_extended_enable_out)
    else $error("range pin acted with a mode strap low");

  // chip-select configuration never reports a long delay
  delay_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ10]
    serial_chip_select_enable_out |-> !calibration_delay_long_out)
    else $error("long delay shown in chip-select configuration");

  // extended mode passes the adjust register through
  adjust_path_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ12]
    ext_mode |=> (full_scale_code_out == $past(full_scale_adjust_in)))
    else $error("full-scale code not taken from adjust register");

  // strobe exactly one cycle after a falling positive-leg edge
  sample_edge_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ11]
    $fell(input_clock_p_in) |=> sample_strobe_out ##1 !sample_strobe_out)
    else $error("sample strobe missed the falling edge");

  // a qualified initiate in idle starts calibration next cycle
  cal_start_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ13]
    cal_trigger |=> calibration_running_out)
    else $error("calibration did not start after initiate");

  // the running flag tracks the sequencer state
  running_flag_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ14]
    calibration_running_out == (state_r == pin_mode_pkg::ST_CALIBRATE))
    else $error("running flag disagrees with calibration state");

  // a calibration run ends within its length
  cal_end_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ14]
    calibration_running_out |-> (run_len_r <= pin_mode_pkg::CAL_RUN_CYC))
    else $error("calibration ran past its length");

  // a timed state always has the timer running or just finished
  timer_span_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ14]
    (state_r == pin_mode_pkg::ST_POWERUP || state_r == pin_mode_pkg::ST_CALIBRATE)
    |-> (timer_busy || timer_done))
    else $error("timer idle while a timed state waits");

  // exactly one of the three range levels at any time
  three_level_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // [RQ15]
    $onehot({fs_low, fs_mid, fs_high}))
    else $error("range pin level not uniquely resolved");

endmodule : adc_pin_mode_decode
`default_nettype wire

// >>> sim/strap_host_model.sv
// host-side model driving the range pad, input clock leg and calibration initiate pin
`timescale 1ns/1ns
`default_nettype none
module strap_host_model (
  // clock
  input wire logic clock_in,
  // requests from the bench
  input wire pin_mode_pkg::level_t range_level_in,
  input wire logic clock_run_in,
  input wire logic cal_start_in,
  input wire logic [12:0] cal_low_cyc_in,
  // pins toward the device
  output logic range_above_out,
  output logic range_below_out,
  output logic input_clock_p_out,
  output logic calibration_initiate_out
);
  logic run_q = 1'b0; // requests taken at rising edge, so no race with bench
  logic start_q = 1'b0;
  logic start_d_r = 1'b0; // previous start request, for edge detect
  logic [1:0] phase_r = 2'h0; // input clock phase, four cycles a period
  logic [12:0] low_cnt_r = 13'h0000; // low cycles still to hold on initiate

  // floating pad: neither comparator trips, so the device sees mid level
  assign range_above_out = (range_level_in == pin_mode_pkg::LVL_HIGH);
  assign range_below_out = (range_level_in == pin_mode_pkg::LVL_LOW);
  // clock leg stands low while stopped
  assign input_clock_p_out = phase_r[1];
  // initiate low while counting, then held high
  assign calibration_initiate_out = (low_cnt_r == 13'h0000);

  // sample bench requests half a cycle before acting on them
  always @(posedge clock_in) begin
    run_q <= clock_run_in;
    start_q <= cal_start_in;
  end

  // drive pins after the falling edge, like a real board controller
  always @(negedge clock_in) begin
    start_d_r <= start_q;
    phase_r <= run_q ? phase_r + 2'h1 : 2'h0;
    if (start_q && !start_d_r) begin
      low_cnt_r <= cal_low_cyc_in;
    end else if (low_cnt_r != 13'h0000) begin
      low_cnt_r <= low_cnt_r - 13'h0001;
    end
  end
endmodule : strap_host_model
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the converter pin-mode decode block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // bench-driven inputs, all moved after the falling edge
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic extended_enable_n = 1'b1; // primary enable, active low
  logic clk_rst_mode = 1'b1;
  logic delay_pin = 1'b0;
  logic [8:0] adjust = 9'h100;
  pin_mode_pkg::level_t range_level = pin_mode_pkg::LVL_HIGH;
  logic clock_run = 1'b0;
  logic cal_start = 1'b0;
  logic [12:0] cal_low = 13'h0050;
  // model pins and design outputs
  logic above, below, clk_p, initiate;
  logic ext, alt, diff, neg, cs_en, cs, dly_long, from_reg, running, strobe;
  logic [8:0] code;
  // scoreboard
  int n_mismatch = 0;
  int checked = 0;
  int falls = 0;
  int strobes = 0;
  logic count_en = 1'b0;
  logic clk_p_d = 1'b0;

  // 20 MHz clock
  always #25 clock_in = ~clock_in;

  strap_host_model u_strap_host_model (
    .clock_in(clock_in), .range_level_in(range_level), .clock_run_in(clock_run),
    .cal_start_in(cal_start), .cal_low_cyc_in(cal_low), .range_above_out(above),
    .range_below_out(below), .input_clock_p_out(clk_p), .calibration_initiate_out(initiate)
  );

  adc_pin_mode_decode u_adc_pin_mode_decode (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .full_scale_select_above_in(above),
    .full_scale_select_below_in(below), .extended_enable_n_in(extended_enable_n),
    .output_clock_reset_mode_in(clk_rst_mode), .calibration_delay_select_in(delay_pin),
    .calibration_initiate_in(initiate), .input_clock_p_in(clk_p),
    .full_scale_adjust_in(adjust), .extended_mode_out(ext),
    .alternate_extended_enable_out(alt), .output_clock_reset_diff_out(diff),
    .output_clock_reset_neg_out(neg), .serial_chip_select_enable_out(cs_en),
    .serial_chip_select_out(cs), .calibration_delay_long_out(dly_long),
    .full_scale_code_out(code), .full_scale_from_register_out(from_reg),
    .calibration_running_out(running), .sample_strobe_out(strobe)
  );

  // count clock-leg falls and strobes seen at the sampling edge
  always @(posedge clock_in) begin
    clk_p_d <= clk_p;
    if (count_en && clk_p_d === 1'b1 && clk_p === 1'b0) falls++;
    if (count_en && strobe === 1'b1) strobes++;
  end

  // single comparison point
  task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // strap setting, applied after a falling edge
  task automatic set_straps(input logic ecn, input logic m, input pin_mode_pkg::level_t lv,
                            input logic d);
    extended_enable_n = ecn;
    clk_rst_mode = m;
    range_level = lv;
    delay_pin = d;
  endtask : set_straps

  // reset held three cycles; reset values looked at while held
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clock_in);
    check("rst_flags", 13'({ext, alt, diff, neg, cs_en, cs, dly_long, from_reg, running}), 13'h0);
    check("rst_code", 13'(code), 13'h01FF);
    sys_rst_in = 1'b0;
  endtask : do_reset

  // running must hold for the whole sequence, then drop
  task automatic cal_length();
    int n;
    n = 0;
    while (running === 1'b1 && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    check("cal_length", 13'(n >= 1398 && n <= 1402), 13'h1);
  endtask : cal_length

  // power-up delay chosen by the delay pin, or forced short in chip-select use
  task automatic test_powerup(input logic ecn, input logic d, input int base);
    int n;
    n = 0;
    set_straps(ecn, 1'b1, pin_mode_pkg::LVL_HIGH, d);
    do_reset();
    while (running !== 1'b1 && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    check("powerup_delay", 13'(n >= base && n <= base + 4), 13'h1);
    check("delay_long", 13'(dly_long), 13'(ecn & d));
    cal_length();
  endtask : test_powerup

  // every strap combination against the decode rules
  task automatic test_decode();
    logic x, lo, md;
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 2; m++) begin
        for (int l = 0; l < 3; l++) begin // three pad levels
          for (int d = 0; d < 2; d++) begin
            set_straps(e[0], m[0], pin_mode_pkg::level_t'(l), d[0]);
            adjust = 9'h100 + 9'(e * 12 + m * 6 + l * 2 + d);
            repeat (3) @(negedge clock_in);
            lo = (l == 0);
            md = (l == 1);
            x = !e[0] | (m[0] & md);
            check("ext_mode", 13'(ext), 13'(x));
            check("alt_enable", 13'(alt), 13'(e[0] & m[0] & md));
            check("clk_rst_diff", 13'(diff), 13'(!m[0]));
            check("clk_rst_neg", 13'(neg), 13'(!m[0] & !lo));
            check("cs_enable", 13'(cs_en), 13'(x));
            check("cs_level", 13'(cs), 13'(x & d[0]));
            check("delay_long", 13'(dly_long), 13'(!x & d[0]));
            check("fs_from_reg", 13'(from_reg), 13'(x));
            check("fs_code", 13'(code), 13'(x ? adjust : (!m[0] || !lo) ? 9'h1FF : 9'h0C0));
          end
        end
      end
    end
  endtask : test_decode

  // one strobe for every fall of the clock leg, none otherwise
  task automatic test_sample();
    falls = 0;
    strobes = 0;
    count_en = 1'b1;
    clock_run = 1'b1;
    repeat (41) @(negedge clock_in);
    clock_run = 1'b0;
    repeat (6) @(negedge clock_in);
    count_en = 1'b0;
    check("falls_seen", 13'(falls >= 9), 13'h1);
    check("strobes", 13'(strobes), 13'(falls));
  endtask : test_sample

  // initiate low for the given span then high; short lows are ignored
  task automatic test_initiate(input logic [12:0] low, input logic go);
    int n;
    n = 0;
    cal_low = low;
    cal_start = 1'b1;
    while (running !== 1'b1 && n < 400) begin
      @(negedge clock_in);
      n++;
    end
    cal_start = 1'b0;
    check("cal_started", 13'(n < 400), 13'(go));
    if (go) begin
      check("cal_latency", 13'(n >= low + 80 && n <= low + 88), 13'h1);
      cal_length();
    end
  endtask : test_initiate

  // main sequence
  initial begin
    test_powerup(1'b1, 1'b0, 256);
    test_powerup(1'b1, 1'b1, 4096);
    test_powerup(1'b0, 1'b1, 256);
    test_decode();
    set_straps(1'b1, 1'b1, pin_mode_pkg::LVL_LOW, 1'b0);
    test_sample();
    test_initiate(13'h0050, 1'b1);
    test_initiate(13'h0028, 1'b0);
    final_report();
  end

  // watchdog: all tests fit well inside 40000 cycles
  initial begin
    repeat (40000) @(posedge clock_in);
    n_mismatch++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
